// >>> hdl/mhca_consts.svh
// constants of the memory handshake command agent: offsets, fields, reset values
// assumes inclusion by bare name from the package and the agent module
`ifndef MHCA_CONSTS_SVH
`define MHCA_CONSTS_SVH

// apb register byte offsets
`define MHCA_OFF_CTRL     8'h00
`define MHCA_OFF_UP_BASE  8'h04
`define MHCA_OFF_DN_BASE  8'h08
`define MHCA_OFF_UP_CNT   8'h0C
`define MHCA_OFF_DN_CNT   8'h10
`define MHCA_OFF_SET_MIN  8'h14
`define MHCA_OFF_SET_MAX  8'h18
`define MHCA_OFF_STATUS   8'h1C
`define MHCA_OFF_LAST_CMD 8'h20
`define MHCA_OFF_SETVAL   8'h40
`define MHCA_OFF_MONITOR  8'h60

// request word values
`define MHCA_REQ_STOP     16'h0000
`define MHCA_REQ_SINGLE   16'h0001
`define MHCA_REQ_MULTI    16'h0002
`define MHCA_REQ_VAR3     16'h0003
`define MHCA_REQ_VAR4     16'h0004

// word offsets inside the shared areas
`define MHCA_WORD_CODE    4'h3
`define MHCA_WORD_VALUES  16'h0004
`define MHCA_LAST_HDR     4'h3

// communications status liveness bit
`define MHCA_LIVE_BIT     15

// command word fields
`define MHCA_CMD_OP_HI    15
`define MHCA_CMD_OP_LO    10
`define MHCA_CMD_UNIT_HI  9
`define MHCA_CMD_UNIT_LO  4
`define MHCA_CMD_ALL_UNIT 3
`define MHCA_CMD_INFO_HI  2
`define MHCA_CMD_INFO_LO  1
`define MHCA_CMD_ALL_CH   0

// reset values and the count limit
`define MHCA_RST_UP_BASE  16'h0000
`define MHCA_RST_DN_BASE  16'h05DC
`define MHCA_RST_CNT      4'h0
`define MHCA_RST_SET_MIN  16'h8000
`define MHCA_RST_SET_MAX  16'h7FFF
`define MHCA_MAX_CNT      4'h8

`endif

// >>> hdl/mhca_pkg.sv
// types of the memory handshake command agent
// assumes the constants header sits beside it
`default_nettype none
`include "mhca_consts.svh"

package mhca_pkg;

	// scan sequencer, one-hot
	typedef enum logic [5:0] {
		MHCA_ST_IDLE = 6'b00_0001,
		MHCA_ST_POLL = 6'b00_0010,
		MHCA_ST_READ = 6'b00_0100,
		MHCA_ST_SET  = 6'b00_1000,
		MHCA_ST_CMD  = 6'b01_0000,
		MHCA_ST_RESP = 6'b10_0000
	} mhca_state_t;

	// function slots of the request and response words
	typedef enum logic [1:0] {
		MHCA_FN_READ = 2'd0,
		MHCA_FN_SET  = 2'd1,
		MHCA_FN_CMD  = 2'd2
	} mhca_fn_t;

endpackage

`default_nettype wire

// >>> hdl/mhca_agent.sv
// memory handshake command agent: scans request words in controller memory,
// uploads monitor or set values, applies downloads and issues operation commands
// assumes a memory port that holds each access until mem_ack, and an apb master
`timescale 1ns/1ps
`default_nettype none
`include "mhca_consts.svh"

module mhca_agent
	import mhca_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             mem_req,
	output logic             mem_we,
	output logic      [15:0] mem_addr,
	output logic      [15:0] mem_wdata,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ack,
	output logic             cmd_valid,
	output logic      [15:0] cmd_code,
	output logic      [15:0] cmd_chan_mask,
	output logic      [5:0]  cmd_op,
	output logic      [5:0]  cmd_unit,
	output logic             cmd_all_units,
	output logic      [1:0]  cmd_info,
	output logic             cmd_all_ch
);

	////////////////////////////////////////////////////////////////////////
	// state
	mhca_state_t  state_ff;
	mhca_state_t  nxt_state;
	logic [3:0]   widx_ff;
	logic [15:0]  req_ff      [0:2];
	logic [15:0]  rsp_ff      [0:2];
	logic [2:0]   do_ff;
	logic [2:0]   first_ff;
	logic [15:0]  code_ff;
	logic [15:0]  prevcode_ff;
	logic         live_ff;
	logic         mem_req_ff;
	logic         mem_we_ff;
	logic [15:0]  mem_addr_ff;
	logic [15:0]  mem_wdata_ff;
	logic [15:0]  setval_ff   [0:7];
	logic [15:0]  prev_ff     [0:7];
	logic [15:0]  mon_ff      [0:7];
	logic         en_ff;
	logic [15:0]  up_base_ff;
	logic [15:0]  dn_base_ff;
	logic [3:0]   up_cnt_ff;
	logic [3:0]   dn_cnt_ff;
	logic [15:0]  set_min_ff;
	logic [15:0]  set_max_ff;
	logic [31:0]  prdata_ff;
	logic         pready_ff;
	logic         pslverr_ff;
	logic         cmd_valid_ff;
	logic [15:0]  cmd_code_ff;
	logic [15:0]  cmd_mask_ff;
	logic         op_need;
	logic         op_we;
	logic         op_last;
	logic [15:0]  op_addr;
	logic [15:0]  op_data;
	logic         op_done;
	logic         poll_done;
	logic [3:0]   rd_cnt;
	logic         rd_mon;
	logic         set_apply;
	logic         cmd_issue;
	logic         apb_acc;
	logic [2:0]   pidx;

	// mode classes of a request value per function
	function automatic logic is_single(input int fn, input logic [15:0] v);
		logic r;
		r = 1'b0;
		case (fn)
			0:       r = (v == `MHCA_REQ_SINGLE) || (v == `MHCA_REQ_VAR3) || (v == `MHCA_REQ_VAR4);
			1:       r = (v == `MHCA_REQ_SINGLE);
			default: r = (v == `MHCA_REQ_SINGLE) || (v == `MHCA_REQ_VAR3);
		endcase
		return r;
	endfunction

	function automatic logic is_multi(input int fn, input logic [15:0] v);
		logic r;
		r = 1'b0;
		case (fn)
			2:       r = (v == `MHCA_REQ_MULTI) || (v == `MHCA_REQ_VAR4);
			default: r = (v == `MHCA_REQ_MULTI);
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// memory access plan for the current state and word index
	assign rd_mon    = (req_ff[0] == `MHCA_REQ_SINGLE) || (req_ff[0] == `MHCA_REQ_MULTI);
	assign rd_cnt    = rd_mon ? up_cnt_ff : dn_cnt_ff;
	assign op_done   = mem_req_ff && mem_ack;
	assign poll_done = (state_ff == MHCA_ST_POLL) && op_done && op_last;

	always_comb begin
		op_need = 1'b0;
		op_we   = 1'b0;
		op_last = 1'b0;
		op_addr = 16'h0000;
		op_data = 16'h0000;
		case (state_ff)
			MHCA_ST_POLL: begin
				// header words: three requests then the command code
				op_need = 1'b1;
				op_addr = dn_base_ff + {12'h000, widx_ff};
				op_last = (widx_ff == `MHCA_LAST_HDR);
			end
			MHCA_ST_READ: begin
				op_need = do_ff[0] && (widx_ff < rd_cnt);
				op_we   = 1'b1;
				// set values go to the download area only in read-setting-2
				op_addr = ((req_ff[0] == `MHCA_REQ_VAR4) ? dn_base_ff : up_base_ff)
					+ `MHCA_WORD_VALUES + {12'h000, widx_ff};
				// monitor list or set value list
				op_data = rd_mon ? mon_ff[widx_ff[2:0]] : setval_ff[widx_ff[2:0]];
				op_last = (widx_ff == rd_cnt - 4'd1);
			end
			MHCA_ST_SET: begin
				op_need = do_ff[1] && (widx_ff < dn_cnt_ff);
				op_addr = dn_base_ff + `MHCA_WORD_VALUES + {12'h000, widx_ff};
				op_last = (widx_ff == dn_cnt_ff - 4'd1);
			end
			MHCA_ST_RESP: begin
				op_need = 1'b1;
				op_we   = 1'b1;
				op_addr = up_base_ff + {12'h000, widx_ff};
				op_last = (widx_ff == `MHCA_LAST_HDR);
				case (widx_ff)
					4'd0:    op_data = rsp_ff[0];
					4'd1:    op_data = rsp_ff[1];
					4'd2:    op_data = rsp_ff[2];
					default: op_data = {live_ff, 15'h0000};
				endcase
			end
			default: begin
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// scan sequencer; a stop is only seen at the next poll, so a scan always completes
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			MHCA_ST_IDLE: if (en_ff) nxt_state = MHCA_ST_POLL;
			MHCA_ST_POLL: if (op_done && op_last) nxt_state = MHCA_ST_READ;
			MHCA_ST_READ: if ((op_done && op_last) || (!mem_req_ff && !op_need)) nxt_state = MHCA_ST_SET;
			MHCA_ST_SET:  if ((op_done && op_last) || (!mem_req_ff && !op_need)) nxt_state = MHCA_ST_CMD;
			MHCA_ST_CMD:  nxt_state = MHCA_ST_RESP;
			MHCA_ST_RESP: if (op_done && op_last) nxt_state = MHCA_ST_IDLE;
			default:      nxt_state = MHCA_ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= MHCA_ST_IDLE;
			widx_ff  <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff)
				widx_ff <= 4'h0;
			else if (op_done)
				widx_ff <= widx_ff + 4'd1;
		end
	end

	// memory master: one access held until acknowledged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req_ff   <= 1'b0;
			mem_we_ff    <= 1'b0;
			mem_addr_ff  <= 16'h0000;
			mem_wdata_ff <= 16'h0000;
		end else if (op_done) begin
			mem_req_ff <= 1'b0;
		end else if (!mem_req_ff && op_need) begin
			mem_req_ff   <= 1'b1;
			mem_we_ff    <= op_we;
			mem_addr_ff  <= op_addr;
			mem_wdata_ff <= op_data;
		end
	end

	// header words captured during the poll
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_ff[0] <= `MHCA_REQ_STOP;
			req_ff[1] <= `MHCA_REQ_STOP;
			req_ff[2] <= `MHCA_REQ_STOP;
			code_ff   <= 16'h0000;
		end else if (state_ff == MHCA_ST_POLL && op_done) begin
			case (widx_ff)
				4'd0:    req_ff[0] <= mem_rdata;
				4'd1:    req_ff[1] <= mem_rdata;
				4'd2:    req_ff[2] <= mem_rdata;
				default: code_ff <= mem_rdata; // full sixteen bit code
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per function handshake of request and response words
	for (genvar f = 0; f < 3; f++) begin : g_fn
		logic acc_single;
		logic acc_multi;
		logic run_multi;
		logic stop_req;
		logic pass_end;

		// a nonzero change without passing zero matches none of these
		assign acc_single = (rsp_ff[f] == `MHCA_REQ_STOP) && is_single(f, req_ff[f]);
		assign acc_multi  = (rsp_ff[f] == `MHCA_REQ_STOP) && is_multi(f, req_ff[f]);
		assign run_multi  = (rsp_ff[f] == req_ff[f]) && is_multi(f, req_ff[f]);
		assign stop_req   = (req_ff[f] == `MHCA_REQ_STOP) && (rsp_ff[f] != `MHCA_REQ_STOP);
		assign pass_end   = (state_ff == MHCA_ST_CMD);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rsp_ff[f]   <= `MHCA_REQ_STOP;
				do_ff[f]    <= 1'b0;
				first_ff[f] <= 1'b0;
			end else if (poll_done) begin
				do_ff[f] <= acc_single || run_multi;
				if (acc_multi) begin
					rsp_ff[f]   <= req_ff[f]; // multi answers before acting
					first_ff[f] <= 1'b1;
				end else if (stop_req) begin
					rsp_ff[f] <= `MHCA_REQ_STOP;
				end
			end else if (pass_end && do_ff[f]) begin
				do_ff[f]    <= 1'b0;
				first_ff[f] <= 1'b0;
				// single answers once its action is done
				if (is_single(f, req_ff[f]))
					rsp_ff[f] <= req_ff[f];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// liveness toggle after each complete monitor upload list
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			live_ff <= 1'b0;
		else if (state_ff == MHCA_ST_READ && op_done && op_last && rd_mon)
			live_ff <= ~live_ff;
	end

	// downloaded value passes if first or single pass, or changed, and in range
	assign set_apply = (state_ff == MHCA_ST_SET) && op_done
		&& (first_ff[1] || is_single(1, req_ff[1]) || mem_rdata != prev_ff[widx_ff[2:0]])
		&& ($signed(mem_rdata) >= $signed(set_min_ff))
		&& ($signed(mem_rdata) <= $signed(set_max_ff));

	assign pidx    = paddr[4:2];
	assign apb_acc = psel && penable && !pready_ff;

	// set values: downloads win over software; upload area is never read back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				setval_ff[i] <= 16'h0000;
				prev_ff[i]   <= 16'h0000;
			end
		end else begin
			if (state_ff == MHCA_ST_SET && op_done)
				prev_ff[widx_ff[2:0]] <= mem_rdata;
			if (set_apply)
				setval_ff[widx_ff[2:0]] <= mem_rdata; // scaled integer taken as is
			else if (apb_acc && pwrite && paddr[7:5] == 3'(`MHCA_OFF_SETVAL >> 5)
				&& $signed(pwdata[15:0]) >= $signed(set_min_ff)
				&& $signed(pwdata[15:0]) <= $signed(set_max_ff))
				setval_ff[pidx] <= pwdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operation command issue
	assign cmd_issue = (state_ff == MHCA_ST_CMD) && do_ff[2]
		&& (is_single(2, req_ff[2]) || first_ff[2] || code_ff != prevcode_ff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_valid_ff <= 1'b0;
			cmd_code_ff  <= 16'h0000;
			cmd_mask_ff  <= 16'h0000;
			prevcode_ff  <= 16'h0000;
		end else begin
			cmd_valid_ff <= cmd_issue;
			if (state_ff == MHCA_ST_CMD && do_ff[2])
				prevcode_ff <= code_ff;
			if (cmd_issue) begin
				cmd_code_ff <= code_ff;
				// bit mode after first pass names only changed bits
				if (req_ff[2] == `MHCA_REQ_VAR4 && !first_ff[2])
					cmd_mask_ff <= code_ff ^ prevcode_ff;
				else
					cmd_mask_ff <= 16'hFFFF;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave, one wait state; unmapped addresses answer pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_ff      <= 1'b0;
			up_base_ff <= `MHCA_RST_UP_BASE;
			dn_base_ff <= `MHCA_RST_DN_BASE;
			up_cnt_ff  <= `MHCA_RST_CNT;
			dn_cnt_ff  <= `MHCA_RST_CNT;
			set_min_ff <= `MHCA_RST_SET_MIN;
			set_max_ff <= `MHCA_RST_SET_MAX;
			for (int i = 0; i < 8; i++)
				mon_ff[i] <= 16'h0000;
		end else if (apb_acc && pwrite) begin
			case (paddr)
				`MHCA_OFF_CTRL:    en_ff      <= pwdata[0];
				`MHCA_OFF_UP_BASE: up_base_ff <= pwdata[15:0];
				`MHCA_OFF_DN_BASE: dn_base_ff <= pwdata[15:0];
				`MHCA_OFF_UP_CNT:  up_cnt_ff  <= (pwdata[3:0] > `MHCA_MAX_CNT) ? `MHCA_MAX_CNT : pwdata[3:0];
				`MHCA_OFF_DN_CNT:  dn_cnt_ff  <= (pwdata[3:0] > `MHCA_MAX_CNT) ? `MHCA_MAX_CNT : pwdata[3:0];
				`MHCA_OFF_SET_MIN: set_min_ff <= pwdata[15:0];
				`MHCA_OFF_SET_MAX: set_max_ff <= pwdata[15:0];
				default: begin
					if (paddr[7:5] == 3'(`MHCA_OFF_MONITOR >> 5))
						mon_ff[pidx] <= pwdata[15:0];
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= apb_acc;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			if (apb_acc) begin
				case (paddr)
					`MHCA_OFF_CTRL:     prdata_ff <= {31'h0000_0000, en_ff};
					`MHCA_OFF_UP_BASE:  prdata_ff <= {16'h0000, up_base_ff};
					`MHCA_OFF_DN_BASE:  prdata_ff <= {16'h0000, dn_base_ff};
					`MHCA_OFF_UP_CNT:   prdata_ff <= {28'h000_0000, up_cnt_ff};
					`MHCA_OFF_DN_CNT:   prdata_ff <= {28'h000_0000, dn_cnt_ff};
					`MHCA_OFF_SET_MIN:  prdata_ff <= {16'h0000, set_min_ff};
					`MHCA_OFF_SET_MAX:  prdata_ff <= {16'h0000, set_max_ff};
					`MHCA_OFF_STATUS:   prdata_ff <= {live_ff, 3'h0, rsp_ff[2][3:0], rsp_ff[1][3:0],
						rsp_ff[0][3:0], 10'h000, state_ff};
					`MHCA_OFF_LAST_CMD: prdata_ff <= {16'h0000, cmd_code_ff};
					default: begin
						if (paddr[7:5] == 3'(`MHCA_OFF_SETVAL >> 5) && paddr[1:0] == 2'b00)
							prdata_ff <= {16'h0000, setval_ff[pidx]};
						else if (paddr[7:5] == 3'(`MHCA_OFF_MONITOR >> 5) && paddr[1:0] == 2'b00)
							prdata_ff <= {16'h0000, mon_ff[pidx]};
						else
							pslverr_ff <= 1'b1;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flops; command fields split from the held code
	assign prdata        = prdata_ff;
	assign pready        = pready_ff;
	assign pslverr       = pslverr_ff;
	assign mem_req       = mem_req_ff;
	assign mem_we        = mem_we_ff;
	assign mem_addr      = mem_addr_ff;
	assign mem_wdata     = mem_wdata_ff;
	assign cmd_valid     = cmd_valid_ff;
	assign cmd_code      = cmd_code_ff;
	assign cmd_chan_mask = cmd_mask_ff;
	assign cmd_op        = cmd_code_ff[`MHCA_CMD_OP_HI:`MHCA_CMD_OP_LO];
	assign cmd_unit      = cmd_code_ff[`MHCA_CMD_UNIT_HI:`MHCA_CMD_UNIT_LO];
	assign cmd_all_units = cmd_code_ff[`MHCA_CMD_ALL_UNIT];
	assign cmd_info      = cmd_code_ff[`MHCA_CMD_INFO_HI:`MHCA_CMD_INFO_LO];
	assign cmd_all_ch    = cmd_code_ff[`MHCA_CMD_ALL_CH];

endmodule // mhca_agent

`default_nettype wire

// >>> verification/mhca_ctl_mem.sv
// controller memory model: 64 shared words behind the agent's memory port
// assumes upload base 0, so word 3 is the status word that closes a scan
`timescale 1ns/1ps
`default_nettype none

module mhca_ctl_mem (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic [2:0]  delay,
	output logic      [15:0] mem_rdata,
	output logic             mem_ack
);
	logic [15:0] ram [0:63];
	logic [2:0]  wait_ff;
	logic [5:0]  idx;
	int          scan_cnt;

	assign idx = mem_addr[5:0];

	////////////////////////////////////////////////////////////
	// answer after a random wait; idle data flips so no stale word survives
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack   <= 1'b0;
			mem_rdata <= 16'h0000;
			wait_ff   <= 3'h0;
			scan_cnt  <= 0;
			for (int i = 0; i < 64; i++) ram[i] <= 16'h0000;
		end else begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && wait_ff >= delay) begin
				mem_ack <= 1'b1;
				wait_ff <= 3'h0;
				if (mem_we) ram[idx] <= mem_wdata;
				else mem_rdata <= ram[idx];
				if (mem_we && idx == 6'h03) scan_cnt <= scan_cnt + 1; // status word ends a scan
			end else if (mem_req && !mem_ack) begin
				wait_ff <= wait_ff + 3'h1;
			end
		end
	end
endmodule // mhca_ctl_mem

`default_nettype wire

// >>> verification/mhca_agent_checker.sv
// port-level timing checks of the memory handshake command agent
// assumes one clock domain; bound onto every agent instance
`timescale 1ns/1ps
`default_nettype none

module mhca_agent_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic        mem_ack,
	input wire logic        cmd_valid,
	input wire logic [15:0] cmd_code,
	input wire logic [5:0]  cmd_op,
	input wire logic [5:0]  cmd_unit,
	input wire logic        cmd_all_units,
	input wire logic [1:0]  cmd_info,
	input wire logic        cmd_all_ch
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////
	// memory port: held until acked, then one idle cycle
	sequence s_waiting;
		mem_req && !mem_ack;
	endsequence
	sequence s_acked;
		mem_req && mem_ack;
	endsequence
	property p_req_hold;
		s_waiting |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("memory access moved before ack");
	property p_req_gap;
		s_acked |=> !mem_req;
	endproperty
	a_req_gap: assert property (p_req_gap) else $error("no idle cycle after ack");

	////////////////////////////////////////////////////////////
	// apb: one wait cycle, one-cycle answer
	sequence s_taken;
		psel && penable && !pready;
	endsequence
	property p_apb_ans;
		s_taken |=> pready ##1 !pready;
	endproperty
	a_apb_ans: assert property (p_apb_ans) else $error("apb answer not one cycle after access");
	property p_err_pulse;
		pslverr |-> pready;
	endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("error without ready");
	property p_rd_idle;
		!pready |-> prdata == 32'h0000_0000 && !pslverr;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");

	////////////////////////////////////////////////////////////
	// command outputs: pulse, fields, code held between issues
	property p_cmd_fields;
		{cmd_op, cmd_unit, cmd_all_units, cmd_info, cmd_all_ch} == cmd_code;
	endproperty
	a_cmd_fields: assert property (p_cmd_fields) else $error("command fields off code");
	property p_cmd_pulse;
		cmd_valid |=> !cmd_valid;
	endproperty
	a_cmd_pulse: assert property (p_cmd_pulse) else $error("command valid longer than a cycle");
	property p_code_held;
		!cmd_valid |-> $stable(cmd_code);
	endproperty
	a_code_held: assert property (p_code_held) else $error("code moved without issue");
endmodule // mhca_agent_checker

bind mhca_agent mhca_agent_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .cmd_valid(cmd_valid),
	.cmd_code(cmd_code), .cmd_op(cmd_op), .cmd_unit(cmd_unit), .cmd_all_units(cmd_all_units),
	.cmd_info(cmd_info), .cmd_all_ch(cmd_all_ch));

`default_nettype wire

// >>> verification/mhca_agent_tb.sv
// bench of the memory handshake command agent: apb set-up, read, setting and command scans
// assumes the memory model with upload base 0 and download base 20h
`timescale 1ns/1ps
`default_nettype none

module mhca_agent_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, errv, live;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv, seed;
	logic        mem_req, mem_we, mem_ack, cmd_valid, cmd_all_units, cmd_all_ch;
	logic [15:0] mem_addr, mem_wdata, mem_rdata, cmd_code, cmd_chan_mask, code, code2, nv;
	logic [15:0] v [0:1];
	logic [5:0]  cmd_op, cmd_unit;
	logic [1:0]  cmd_info;
	logic [2:0]  delay = 3'h0;
	logic [31:0] dseed = 32'h0000_a0ad;
	int          n_fail, samples_checked, n0;
	int          n_cmd = 0;

	mhca_agent dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_chan_mask(cmd_chan_mask), .cmd_op(cmd_op), .cmd_unit(cmd_unit),
		.cmd_all_units(cmd_all_units), .cmd_info(cmd_info), .cmd_all_ch(cmd_all_ch));
	mhca_ctl_mem u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .delay(delay), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack));

	////////////////////////////////////////////////////////////
	// clock, random memory latency, command pulse count
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		dseed <= lfsr(dseed);
		delay <= dseed[6:4];
		if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function logic [15:0] rnd(input logic [15:0] lim);
		seed = lfsr(seed);
		return 16'(seed % lim);
	endfunction
	function automatic logic [31:0] w(input int i);
		return {16'h0000, u_mem.ram[i]};
	endfunction

	task automatic end_sim();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// setup then access, held until pready; an edge first keeps drives apart
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 40);
		rdv = prdata;
		errv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 40) begin
			n_fail++;
			end_sim();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic mw(input int i, input logic [15:0] d);
		@(posedge pclk);
		u_mem.ram[i] <= d;
	endtask
	// a scan ends with the status write; bounded so a stall cannot hang
	task automatic scans(input int k);
		int s0, t;
		s0 = u_mem.scan_cnt;
		t = 0;
		while (u_mem.scan_cnt < s0 + k && t < 3000) begin
			@(posedge pclk);
			t++;
		end
		if (t >= 3000) begin
			n_fail++;
			end_sim();
		end
	endtask

	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		seed = 32'h0000_a0ad;
		n_fail = 0;
		samples_checked = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h08);
		chk(rdv, 32'h0000_05DC);
		rd(8'h14);
		chk(rdv, 32'h0000_8000);
		rd(8'h18);
		chk(rdv, 32'h0000_7FFF);
		rd(8'h30);
		chk({errv, rdv[30:0]}, 32'h8000_0000);
		wr(8'h0C, 32'h0000_0009);
		rd(8'h0C);
		chk(rdv, 32'h0000_0008);
		wr(8'h0C, 32'h0000_0002);
		wr(8'h04, 32'h0000_0000);
		wr(8'h08, 32'h0000_0020);
		wr(8'h10, 32'h0000_0002);
		wr(8'h14, 32'h0000_0000);
		wr(8'h18, 32'h0000_03E8);
		wr(8'h00, 32'h0000_0001);
		// read modes: monitor or set values land at the chosen area
		for (int md = 1; md <= 4; md++) begin
			for (int i = 0; i < 2; i++) begin
				v[i] = rnd(16'h03E9);
				wr((md < 3 ? 8'h60 : 8'h40) + 8'(4 * i), {16'h0000, v[i]});
				mw((md == 4 ? 36 : 4) + i, ~v[i]);
			end
			live = u_mem.ram[3][15];
			mw(32, 16'(md));
			scans(3);
			chk(w(0), md);
			rd(8'h1C);
			chk({28'h000_0000, rdv[19:16]}, md);
			for (int i = 0; i < 2; i++) chk(w((md == 4 ? 36 : 4) + i), {16'h0000, v[i]});
			if (md == 2) live = u_mem.ram[3][15];
			if (md == 2) scans(1);
			if (md < 3) chk(w(3) >> 15, {31'h0000_0000, ~live});
			nv = 16'((v[0] + 1) % 1001);
			wr(md < 3 ? 8'h60 : 8'h40, {16'h0000, nv});
			scans(2);
			chk(w(md == 4 ? 36 : 4), {16'h0000, md == 2 ? nv : v[0]});
			if (md == 1) mw(32, 16'h0002);
			if (md == 1) scans(2);
			chk(w(0), md);
			mw(32, 16'h0000);
			scans(2);
			chk(w(0), 32'h0000_0000);
		end
		// single setting change: top of range taken, one above refused
		wr(8'h44, 32'h0000_0123);
		mw(36, 16'h03E8);
		mw(37, 16'h03E9);
		mw(33, 16'h0001);
		scans(3);
		rd(8'h40);
		chk(rdv, 32'h0000_03E8);
		rd(8'h44);
		chk(rdv, 32'h0000_0123);
		wr(8'h44, 32'h0000_03E9);
		rd(8'h44);
		chk(rdv, 32'h0000_0123);
		chk(w(1), 32'h0000_0001);
		mw(33, 16'h0000);
		scans(2);
		chk(w(1), 32'h0000_0000);
		// multi setting change: all first, then only changed words
		mw(37, 16'h0100);
		mw(33, 16'h0002);
		scans(3);
		rd(8'h44);
		chk(rdv, 32'h0000_0100);
		wr(8'h40, 32'h0000_0007);
		mw(4, 16'h0055);
		mw(37, 16'h0200);
		scans(2);
		rd(8'h40);
		chk(rdv, 32'h0000_0007);
		rd(8'h44);
		chk(rdv, 32'h0000_0200);
		mw(33, 16'h0000);
		scans(2);
		// command modes: once per request, reissue on code change only
		for (int md = 1; md <= 4; md++) begin
			code = rnd(16'hFFFF);
			mw(35, code);
			mw(34, 16'(md));
			n0 = n_cmd;
			scans(3);
			chk(n_cmd - n0, 32'h0000_0001);
			chk({16'h0000, cmd_op, cmd_unit, cmd_all_units, cmd_info, cmd_all_ch}, {16'h0000, code});
			chk({16'h0000, cmd_chan_mask}, 32'h0000_FFFF);
			rd(8'h20);
			chk(rdv, {16'h0000, code});
			scans(2);
			chk(n_cmd - n0, 32'h0000_0001);
			if (md % 2 == 0) begin
				code2 = code ^ (rnd(16'hFFFF) | 16'h0001);
				mw(35, code2);
				scans(2);
				chk(n_cmd - n0, 32'h0000_0002);
				chk({16'h0000, cmd_code}, {16'h0000, code2});
				chk({16'h0000, cmd_chan_mask}, {16'h0000, md == 4 ? code ^ code2 : 16'hFFFF});
			end
			mw(34, 16'h0000);
			scans(2);
			chk(w(2), 32'h0000_0000);
		end
		end_sim();
	end
endmodule // mhca_agent_tb

`default_nettype wire
